/* core/twtl_loader.sv */
// Top: three-wire tuning word loader with forced three-wire settings
//
// Function
// RL1: Controller drives data, shift clock and strobe on the select/strobe pin.
// RL2: Shift one bit per falling shift clock edge while strobe is high.
// RL3: Clock edges with strobe low shift nothing and count nothing.
// RL4: On strobe fall, latch word only after exactly nineteen pulses.
// RL5: Word holds fifteen divider bits plus port bits, nothing else.
// RL6: Three-wire mode turns the first port into the lock output.
// RL7: Lock output sinks when loop is locked, released otherwise.
// RL8: Charge pump high current is forced on.
// RL9: Divider test off and charge pump enabled are forced.
// RL10: Prescaler on and varicap drive enabled are forced.
// RL11: Reference ratio from select level: low 1024, mid 512, high 640.
// RL12: Divider value zero disables the whole loop.
// RL13: Divider bits are binary weighted, MSB 16384, LSB one.
// RL14: Port bit one turns its output on, zero releases it.
// RL15: Word is MSB first: fifteen divider bits then four port bits.
`timescale 1ns/1ps
module twtl_loader
   import twtl_pkg::*;
#(
   parameter int unsigned SF_W   = SF_BITS,
   parameter int unsigned PORT_W = PORT_BITS
) (
   input  wire logic              core_clk_i,
   input  wire logic              nrst_i,
   input  wire logic              data_i,
   input  wire logic              shift_clk_i,
   input  wire logic              select_strobe_pin_i,
   input  wire twtl_ref_e         ref_ratio_select_pin_i,
   input  wire logic              loop_locked_i,
   output logic [SF_W-1:0]        scale_factor_o,
   output logic [PORT_W-2:0]      port_switch_bits_o,
   output logic [PORT_W-2:0]      port_switch_oe_o,
   output logic                   port_one_or_lock_output_o,
   output logic                   port_one_or_lock_oe_o,
   output logic [10:0]            ref_ratio_o,
   output logic                   pll_enable_o,
   output logic                   pump_current_high_bit_o,
   output logic                   divider_test_bit_o,
   output logic                   pump_disable_bit_o,
   output logic                   prescaler_on_bit_o,
   output logic                   varicap_disable_bit_o,
   output logic                   word_loaded_o,
   output logic                   frame_rejected_o
);
   localparam int unsigned W = SF_W + PORT_W;

   // ----------------------------------------
   // Pin capture
   // ----------------------------------------
   twtl_edge_if edges ();

   twtl_pin_sync u_sync (
      .core_clk_i  (core_clk_i),
      .nrst_i      (nrst_i),
      .data_i      (data_i),
      .shift_clk_i (shift_clk_i),
      .strobe_i    (select_strobe_pin_i),
      .edges       (edges)
   );

   // ----------------------------------------
   // Shift register and pulse count
   // ----------------------------------------
   logic [W-1:0] shift_reg;
   logic [W-1:0] shift_next;
   logic [4:0]   count_reg;
   logic [4:0]   count_next;
   logic         overflow_reg;
   logic         overflow_next;

   // Shift only inside the strobe window; edges outside it are dropped
   wire take_bit = edges.clk_fall & edges.strobe_lvl;                    // RL2 RL3
   // A strobe fall ends the window, so the same cycle cannot also shift
   wire count_ok = (count_reg == FRAME_PULSES) & ~overflow_reg;          // RL4
   wire accept   = edges.strobe_fall & count_ok;                         // RL4

   // MSB arrives first, so new bits enter at the bottom
   assign shift_next    = take_bit ? {shift_reg[W-2:0], edges.data_lvl} : shift_reg; // RL15
   // Saturating flag keeps a 51-pulse frame from aliasing back to nineteen
   assign overflow_next = edges.strobe_rise ? 1'b0
                        : (take_bit & (count_reg == 5'h1f)) ? 1'b1 : overflow_reg;
   assign count_next    = edges.strobe_rise ? 5'h00
                        : take_bit ? count_reg + 5'h01 : count_reg;        // RL3

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         shift_reg    <= WORD_RST;
         count_reg    <= 5'h00;
         overflow_reg <= 1'b0;
      end else begin
         shift_reg    <= shift_next;
         count_reg    <= count_next;
         overflow_reg <= overflow_next;
      end
   end

   // ----------------------------------------
   // Working latches
   // ----------------------------------------
   logic [SF_W-1:0]   sf_reg;
   logic [PORT_W-1:0] port_reg;
   logic              loaded_reg;
   logic              reject_reg;

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         sf_reg   <= WORD_RST[SF_W-1:0];
         port_reg <= WORD_RST[PORT_W-1:0];
      end else if (accept) begin
         sf_reg   <= shift_reg[W-1:PORT_W];                             // RL4 RL5 RL15
         port_reg <= shift_reg[PORT_W-1:0];                             // RL5
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         loaded_reg <= 1'b0;
         reject_reg <= 1'b0;
      end else begin
         loaded_reg <= accept;
         reject_reg <= edges.strobe_fall & ~count_ok;                  // RL4
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Straight binary: weight of bit k is two to the k
   assign scale_factor_o = sf_reg;                                       // RL13
   assign pll_enable_o   = (sf_reg != SF_PLL_OFF[SF_W-1:0]);             // RL12

   // Port word order: port seven, six, five, four; first port is lock here
   genvar g;
   generate
      for (g = 0; g < PORT_W - 1; g++) begin : g_port
         assign port_switch_bits_o[g] = 1'b0;
         assign port_switch_oe_o[g]   = port_reg[g];                     // RL14
      end
   endgenerate

   // Sinks only while locked; open collector never drives high
   assign port_one_or_lock_output_o = 1'b0;                              // RL6
   assign port_one_or_lock_oe_o     = loop_locked_i;                     // RL7

   wire [10:0] ratio_sel = (ref_ratio_select_pin_i == TWTL_REF_LOW)  ? REF_RATIO_LOW
                         : (ref_ratio_select_pin_i == TWTL_REF_HIGH) ? REF_RATIO_HIGH
                         : REF_RATIO_MID;
   assign ref_ratio_o = ratio_sel;                                       // RL11

   assign pump_current_high_bit_o = 1'b1;                                // RL8
   assign divider_test_bit_o      = 1'b0;                                // RL9
   assign pump_disable_bit_o      = 1'b0;                                // RL9
   assign prescaler_on_bit_o      = 1'b1;                                // RL10
   assign varicap_disable_bit_o   = 1'b0;                                // RL10

   assign word_loaded_o    = loaded_reg;
   assign frame_rejected_o = reject_reg;
endmodule

/* common/twtl_pkg.sv */
// Package: constants and types for the three-wire tuning word loader
package twtl_pkg;
   localparam int unsigned WORD_BITS      = 19;
   localparam int unsigned SF_BITS        = 15;
   localparam int unsigned PORT_BITS      = 4;
   localparam logic [4:0]  FRAME_PULSES   = 5'h13;
   localparam logic [18:0] WORD_RST       = 19'h0_0000;
   localparam logic [10:0] REF_RATIO_LOW  = 11'h400;
   localparam logic [10:0] REF_RATIO_MID  = 11'h200;
   localparam logic [10:0] REF_RATIO_HIGH = 11'h280;
   localparam logic [14:0] SF_PLL_OFF     = 15'h0000;
   // Reference select levels as sensed by the analog front end
   typedef enum logic [1:0] {
      TWTL_REF_LOW,
      TWTL_REF_MID,
      TWTL_REF_HIGH
   } twtl_ref_e;
endpackage

/* common/twtl_edge_if.sv */
// Interface: synchronised pin levels and their edge pulses
`timescale 1ns/1ps
interface twtl_edge_if;
   logic data_lvl;
   logic strobe_lvl;
   logic clk_fall;
   logic strobe_fall;
   logic strobe_rise;
   modport producer (output data_lvl, output strobe_lvl, output clk_fall, output strobe_fall, output strobe_rise);
   modport consumer (input data_lvl, input strobe_lvl, input clk_fall, input strobe_fall, input strobe_rise);
endinterface

/* core/twtl_pin_sync.sv */
// Two-stage synchronisers for the three serial pins, edge detection for shift clock and strobe only
`timescale 1ns/1ps
module twtl_pin_sync (
   input  wire logic          core_clk_i,
   input  wire logic          nrst_i,
   input  wire logic          data_i,
   input  wire logic          shift_clk_i,
   input  wire logic          strobe_i,
   twtl_edge_if.producer      edges
);
   // ----------------------------------------
   // Synchronisers
   // ----------------------------------------
   logic [2:0] meta_reg;
   logic [2:0] sync_reg;
   logic [2:0] prev_reg;

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         meta_reg <= 3'h0;
         sync_reg <= 3'h0;
         prev_reg <= 3'h0;
      end else begin
         meta_reg <= {strobe_i, shift_clk_i, data_i};
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign edges.data_lvl    = sync_reg[0];
   assign edges.strobe_lvl  = sync_reg[2];
   assign edges.clk_fall    = prev_reg[1] & ~sync_reg[1];
   assign edges.strobe_fall = prev_reg[2] & ~sync_reg[2];
   assign edges.strobe_rise = ~prev_reg[2] & sync_reg[2];
endmodule

/* test/twtl_sva.sv */
// Checker: port properties of the three-wire loader
`timescale 1ns/1ps
module twtl_sva
   import twtl_pkg::*;
#(
   parameter int unsigned SF_W   = SF_BITS,
   parameter int unsigned PORT_W = PORT_BITS
) (
   input wire logic              core_clk_i, nrst_i, data_i, shift_clk_i, select_strobe_pin_i,
   input wire logic              loop_locked_i, word_loaded_o, frame_rejected_o, pll_enable_o,
   input wire twtl_ref_e         ref_ratio_select_pin_i,
   input wire logic [SF_W-1:0]   scale_factor_o,
   input wire logic [PORT_W-2:0] port_switch_bits_o, port_switch_oe_o,
   input wire logic [10:0]       ref_ratio_o,
   input wire logic              port_one_or_lock_output_o, port_one_or_lock_oe_o, pump_current_high_bit_o,
   input wire logic              divider_test_bit_o, pump_disable_bit_o, prescaler_on_bit_o, varicap_disable_bit_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   // Every strobe fall ends a window and must be answered by exactly one pulse
   sequence s_frame_end;
      $fell(select_strobe_pin_i);
   endsequence
   sequence s_answer;
      word_loaded_o || frame_rejected_o;
   endsequence
   a_frame_answered: assert property (s_frame_end |-> ##3 s_answer)
      else $error("strobe fall not answered");
   a_answer_single: assert property (s_answer |=> !(word_loaded_o || frame_rejected_o))
      else $error("answer pulse too long");
   a_load_after_window: assert property (word_loaded_o |-> !select_strobe_pin_i && $past(select_strobe_pin_i, 7))
      else $error("load without strobe window");
   a_latch_on_load: assert property ($changed({scale_factor_o, port_switch_oe_o}) |-> word_loaded_o)
      else $error("latch moved without load");
   a_pll_off_zero: assert property (pll_enable_o == (scale_factor_o != '0))
      else $error("loop enable wrong");
   a_ref_ratio_map: assert property (ref_ratio_o == ((ref_ratio_select_pin_i == TWTL_REF_LOW) ? 11'h400 :
      (ref_ratio_select_pin_i == TWTL_REF_HIGH) ? 11'h280 : 11'h200))
      else $error("reference ratio wrong");
   a_lock_sinks: assert property (port_one_or_lock_oe_o == loop_locked_i && !port_one_or_lock_output_o)
      else $error("lock output wrong");
   a_ports_open: assert property (port_switch_bits_o == '0)
      else $error("port value not low");
   a_pump_forced: assert property (pump_current_high_bit_o && !pump_disable_bit_o)
      else $error("pump settings wrong");
   a_mode_forced: assert property (prescaler_on_bit_o && !varicap_disable_bit_o && !divider_test_bit_o)
      else $error("mode settings wrong");
endmodule
bind twtl_loader twtl_sva #(.SF_W(SF_W), .PORT_W(PORT_W)) u_sva (.*);

/* test/twtl_ctrl_model.sv */
// Partner: tuner controller driving data, shift clock and strobe
`timescale 1ns/1ps
module twtl_ctrl_model (
   output logic data_o,
   output logic sclk_o,
   output logic strobe_o
);
   initial begin
      data_o = 1'b0;
      sclk_o = 1'b0;
      strobe_o = 1'b0;
   end
   // Sends n bits MSB first; en low pulses the clock with the strobe down
   task automatic send(input logic [39:0] w, input int n, input bit en);
      strobe_o = en;
      #32;
      for (int i = n - 1; i >= 0; i--) begin
         data_o = w[i];
         #16 sclk_o = 1'b1;
         #32 sclk_o = 1'b0;
         #16;
      end
      #32 strobe_o = 1'b0;
      // Released data must not look like a held bit
      data_o = ~data_o;
      #80;
   endtask
endmodule

/* test/testbench.sv */
// Testbench: random and corner frames through the loader
`timescale 1ns/1ps
module testbench;
   import twtl_pkg::*;
   logic        core_clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        data_i, shift_clk_i, select_strobe_pin_i, pll_enable_o, word_loaded_o, frame_rejected_o;
   twtl_ref_e   ref_ratio_select_pin_i = TWTL_REF_LOW;
   logic        loop_locked_i = 1'b0;
   logic [14:0] scale_factor_o;
   logic [2:0]  port_switch_bits_o, port_switch_oe_o;
   logic [10:0] ref_ratio_o;
   logic        port_one_or_lock_output_o, port_one_or_lock_oe_o, pump_current_high_bit_o;
   logic        divider_test_bit_o, pump_disable_bit_o, prescaler_on_bit_o, varicap_disable_bit_o;
   int          fails = 0;
   int          checks = 0;
   logic [18:0] word = 19'h0_0000;
   int          loads = 0;
   int          rejects = 0;
   // Answer pulses stand one cycle, so they are counted as they pass
   always @(posedge core_clk_i) begin
      if (word_loaded_o === 1'b1)
         loads++;
      if (frame_rejected_o === 1'b1)
         rejects++;
   end
   always #4 core_clk_i = ~core_clk_i;
   twtl_ctrl_model ctrl (.data_o(data_i), .sclk_o(shift_clk_i), .strobe_o(select_strobe_pin_i));
   twtl_loader uut (.*);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [10:0] ratio(input twtl_ref_e s);
      return (s == TWTL_REF_LOW) ? 11'h400 : (s == TWTL_REF_HIGH) ? 11'h280 : 11'h200;
   endfunction
   task automatic check_latch();
      check(scale_factor_o, word[18:4]);
      check(port_switch_oe_o, word[2:0]);
      check(pll_enable_o, word[18:4] != 15'h0000);
   endtask
   // Only a nineteen-pulse frame may move the expected word
   task automatic frame(input logic [39:0] w, input int n);
      int l0;
      int r0;
      l0 = loads;
      r0 = rejects;
      ctrl.send(w, n, 1'b1);
      if (n == 19)
         word = w[18:0];
      check_latch();
      check(loads - l0, (n == 19) ? 1 : 0);
      check(rejects - r0, (n != 19) ? 1 : 0);
   endtask
   task automatic end_sim();
      $display("Checks %0d, fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      fails++;
      end_sim();
   end
   initial begin
      void'($urandom(66751));
      repeat (5) @(posedge core_clk_i);
      @(negedge core_clk_i) nrst_i = 1'b1;
      repeat (4) @(negedge core_clk_i);
      check_latch();
      frame(40'h7_ffff, 19);
      frame(40'h0_0005, 19);
      frame(40'h1_2345, 18);
      frame(40'h1_2345, 20);
      frame(40'hff_ffff_ffff, 40);
      ctrl.send(40'h5_5555, 19, 1'b0);
      check_latch();
      for (int i = 0; i < 9; i++) begin
         @(negedge core_clk_i);
         ref_ratio_select_pin_i = twtl_ref_e'(i % 3);
         loop_locked_i = 1'($urandom);
         @(negedge core_clk_i);
         check(ref_ratio_o, ratio(ref_ratio_select_pin_i));
         check(port_one_or_lock_oe_o, loop_locked_i);
         frame(40'($urandom), 19);
      end
      end_sim();
   end
endmodule
